// ==== rtl/pwm_interrupt_flags_and_brake_status.sv ====
// PWM interrupt enables, counter event flags and brake status with APB access
//
// What this block does
// - Level brake irq enable per pair, bits 8-10.
// - Edge brake irq enable per pair, bits 0-2.
// - Brake enables writable only while unlocked.
// - Down-count compare match sets flag, W1C.
// - No down flag if compare equals period.
// - Up-count compare match sets flag, W1C.
// - No up flag if compare equals period.
// - Complementary: odd flags are even second compare.
// - Period flags channels 0/2/4, W1C.
// - Zero flags channels 0/2/4, W1C.
// - Read-only level brake state, hardware cleared.
// - Level brake held until period ends.
// - Edge brake state on falling edge, W1C.
// - Level brake event flag, protected W1C.
// - Edge brake event flag, protected W1C.
`timescale 1ns/1ps
module pwm_interrupt_flags_and_brake_status
    import pwm_irq_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Block inputs
    input wire cnt_events_t cnt_ev,
    input wire logic [2:0] comp_mode,
    input wire brake_in_t brake_src,
    input wire logic regs_unlocked,
    // Interrupt request
    output logic irq
);

    // Bus phase decode
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic irq_q;
    wire access_w = psel & penable & ~pready_q;
    wire done_w = psel & penable & pready_q;
    wire wr_w = done_w & pwrite;
    wire sel_cnt_ien = paddr == OFF_CNT_IEN;
    wire sel_brk_ien = paddr == OFF_BRK_IEN;
    wire sel_cnt_flag = paddr == OFF_CNT_FLAG;
    wire sel_brk_flag = paddr == OFF_BRK_FLAG;
    wire mapped_w = sel_cnt_ien | sel_brk_ien | sel_cnt_flag | sel_brk_flag;
    wire wr_cnt_ien = wr_w & sel_cnt_ien;
    wire wr_brk_ien = wr_w & sel_brk_ien & regs_unlocked;
    wire wr_cnt_flag = wr_w & sel_cnt_flag;
    wire wr_brk_flag = wr_w & sel_brk_flag;
    wire wr_brk_prot = wr_brk_flag & regs_unlocked;

    // Clear strobes per field
    wire [5:0] cmpd_clr = wr_cnt_flag ? pwdata[CMPD_LSB +: NCH] : RESET_FLAGS;
    wire [5:0] cmpu_clr = wr_cnt_flag ? pwdata[CMPU_LSB +: NCH] : RESET_FLAGS;
    wire [5:0] per_clr = wr_cnt_flag ? pwdata[PER_LSB +: NCH] : RESET_FLAGS;
    wire [5:0] zero_clr = wr_cnt_flag ? pwdata[ZERO_LSB +: NCH] : RESET_FLAGS;
    wire [5:0] estate_clr = wr_brk_flag ? pwdata[ESTATE_LSB +: NCH] : RESET_FLAGS;
    wire [5:0] lif_clr = wr_brk_prot ? pwdata[LIF_LSB +: NCH] : RESET_FLAGS;
    wire [5:0] eif_clr = wr_brk_prot ? pwdata[EIF_LSB +: NCH] : RESET_FLAGS;

    // Brake source synchronisers
    logic [5:0] brk_s1_q;
    logic [5:0] brk_s2_q;
    logic [5:0] brk_s3_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_s1_q <= '1;
            brk_s2_q <= '1;
            brk_s3_q <= '1;
        end else begin
            brk_s1_q <= brake_src;
            brk_s2_q <= brk_s1_q;
            brk_s3_q <= brk_s2_q;
        end
    end
    wire [2:0] lvl_low = ~brk_s2_q[5:3];
    wire [2:0] lvl_fall = brk_s3_q[5:3] & ~brk_s2_q[5:3];
    wire [2:0] edge_fall = brk_s3_q[2:0] & ~brk_s2_q[2:0];

    // Enable and flag storage
    logic [31:0] cnt_ien_q;
    logic [2:0] lien_q;
    logic [2:0] eien_q;
    logic [5:0] cmpd_q, cmpd_d, cmpd_set;
    logic [5:0] cmpu_q, cmpu_d, cmpu_set;
    logic [5:0] per_q, per_d;
    logic [5:0] zero_q, zero_d;
    logic [5:0] lstate_q, lstate_d;
    logic [5:0] estate_q, estate_d;
    logic [5:0] lif_q, lif_d;
    logic [5:0] eif_q, eif_d;

    // Period and zero flags exist on even channels only
    wire [5:0] per_set = cnt_ev.per_hit & EVEN_MASK;
    wire [5:0] zero_set = cnt_ev.zero_hit & EVEN_MASK;

    genvar n;
    generate
        for (n = 0; n < NCH; n++) begin : g_ch
            localparam int P = n / 2;
            localparam int E = n - (n % 2);
            wire use_even = comp_mode[P] & (n % 2 == 1);
            wire up_w = use_even ? cnt_ev.cnt_up[E] : cnt_ev.cnt_up[n];
            wire dn_w = use_even ? cnt_ev.cnt_down[E] : cnt_ev.cnt_down[n];
            wire tup_w = use_even ? cnt_ev.type_up[E] : cnt_ev.type_up[n];
            wire tdn_w = use_even ? cnt_ev.type_down[E] : cnt_ev.type_down[n];
            wire pend_w = use_even ? cnt_ev.per_end[E] : cnt_ev.per_end[n];
            assign cmpd_set[n] = cnt_ev.cmp_hit[n] & dn_w & ~(cnt_ev.cmp_eq_per[n] & tdn_w);
            assign cmpu_set[n] = cnt_ev.cmp_hit[n] & up_w & ~(cnt_ev.cmp_eq_per[n] & tup_w);
            // Set wins over a clear in the same cycle
            assign cmpd_d[n] = cmpd_set[n] | (cmpd_q[n] & ~cmpd_clr[n]);
            assign cmpu_d[n] = cmpu_set[n] | (cmpu_q[n] & ~cmpu_clr[n]);
            assign per_d[n] = per_set[n] | (per_q[n] & ~per_clr[n]);
            assign zero_d[n] = zero_set[n] | (zero_q[n] & ~zero_clr[n]);
            // set on fall, no software clear
            // release at period end once source high
            assign lstate_d[n] = lvl_fall[P] | (lstate_q[n] & ~(~lvl_low[P] & pend_w));
            assign estate_d[n] = edge_fall[P] | (estate_q[n] & ~estate_clr[n]);
            assign lif_d[n] = lvl_fall[P] | (lif_q[n] & ~lif_clr[n]);
            assign eif_d[n] = edge_fall[P] | (eif_q[n] & ~eif_clr[n]);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmpd_q <= RESET_FLAGS;
            cmpu_q <= RESET_FLAGS;
            per_q <= RESET_FLAGS;
            zero_q <= RESET_FLAGS;
            lstate_q <= RESET_FLAGS;
            estate_q <= RESET_FLAGS;
            lif_q <= RESET_FLAGS;
            eif_q <= RESET_FLAGS;
        end else begin
            cmpd_q <= cmpd_d;
            cmpu_q <= cmpu_d;
            per_q <= per_d;
            zero_q <= zero_d;
            lstate_q <= lstate_d;
            estate_q <= estate_d;
            lif_q <= lif_d;
            eif_q <= eif_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ien_q <= RESET_WORD;
        end else if (wr_cnt_ien) begin
            cnt_ien_q <= pwdata & CNT_IEN_MASK;
        end
    end

    // Enable fields of the write word
    wire [2:0] lien_wdata = pwdata[LIEN_LSB +: NPAIR];
    wire [2:0] eien_wdata = pwdata[EIEN_LSB +: NPAIR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lien_q <= RESET_PAIR;
            eien_q <= RESET_PAIR;
        end else if (wr_brk_ien) begin
            lien_q <= lien_wdata;
            eien_q <= eien_wdata;
        end
    end

    // Read words
    wire [31:0] cnt_flag_word = (32'(cmpd_q) << CMPD_LSB) | (32'(cmpu_q) << CMPU_LSB)
        | (32'(per_q) << PER_LSB) | (32'(zero_q) << ZERO_LSB);
    wire [31:0] brk_flag_word = (32'(lstate_q) << LSTATE_LSB) | (32'(estate_q) << ESTATE_LSB)
        | (32'(lif_q) << LIF_LSB) | (32'(eif_q) << EIF_LSB);
    wire [31:0] brk_ien_word = (32'(lien_q) << LIEN_LSB) | (32'(eien_q) << EIEN_LSB);
    wire [31:0] rd_word = sel_cnt_ien ? cnt_ien_q
        : sel_brk_ien ? brk_ien_word
        : sel_cnt_flag ? cnt_flag_word
        : sel_brk_flag ? brk_flag_word : RESET_WORD;

    // Interrupt gating
    wire [5:0] lien_ch = {lien_q[2], lien_q[2], lien_q[1], lien_q[1], lien_q[0], lien_q[0]};
    wire [5:0] eien_ch = {eien_q[2], eien_q[2], eien_q[1], eien_q[1], eien_q[0], eien_q[0]};
    wire irq_d = |(cnt_flag_word & cnt_ien_q) | |(lif_q & lien_ch) | |(eif_q & eien_ch);

    // One wait state keeps every bus output registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= RESET_WORD;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            pready_q <= access_w;
            prdata_q <= (access_w && !pwrite) ? rd_word : RESET_WORD;
            pslverr_q <= access_w & ~mapped_w;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cmpd_set: assert property (cmpd_set != 0 |=> (cmpd_q & $past(cmpd_set)) == $past(cmpd_set))
        else $error("down compare flag not set");
    a_cmpd_eqper: assert property (
        (cnt_ev.cmp_eq_per[2] & cnt_ev.type_down[2] & ~cmpd_q[2]) |=> ~cmpd_q[2])
        else $error("down flag raised at period compare");
    a_cmpu_set: assert property (cmpu_set != 0 |=> (cmpu_q & $past(cmpu_set)) == $past(cmpu_set))
        else $error("up compare flag not set");
    a_cmpu_eqper: assert property (
        (cnt_ev.cmp_eq_per[3] & cnt_ev.type_up[3] & ~comp_mode[1] & ~cmpu_q[3]) |=> ~cmpu_q[3])
        else $error("up flag raised at period compare");
    a_odd_per_zero: assert property ((per_q & ~EVEN_MASK) == 0 && (zero_q & ~EVEN_MASK) == 0)
        else $error("odd period or zero flag set");
    a_zero_clear: assert property (
        (wr_cnt_flag & pwdata[ZERO_LSB] & ~zero_set[0]) |=> ~zero_q[0])
        else $error("zero flag not cleared");
    a_lock_hold: assert property (
        (wr_w & sel_brk_ien & ~regs_unlocked) |=> $stable(lien_q) && $stable(eien_q))
        else $error("brake enable changed while locked");
    a_lstate_ro: assert property (
        (lstate_q[0] & lvl_low[0]) |=> lstate_q[0])
        else $error("level brake state dropped while low");
    a_lstate_rel: assert property (
        (lstate_q[0] & ~lvl_low[0] & cnt_ev.per_end[0] & ~comp_mode[0] & ~lvl_fall[0]) |=> ~lstate_q[0])
        else $error("level brake state not released");
    a_lif_lock: assert property (
        (lif_q[0] & ~regs_unlocked) |=> lif_q[0])
        else $error("level event flag cleared while locked");
    a_eif_pair: assert property (edge_fall[1] |=> eif_q[2] & eif_q[3] & estate_q[2] & estate_q[3])
        else $error("edge event flags not set for pair");
    a_estate_clr: assert property (
        (wr_brk_flag & pwdata[ESTATE_LSB] & ~edge_fall[0]) |=> ~estate_q[0])
        else $error("edge state not cleared");
    a_irq_level: assert property (
        (lif_q[0] & lien_q[0]) |=> irq)
        else $error("irq missing for enabled flag");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held more than one cycle");

    // Counter flag clears and complementary pairing
    a_cmpd_clear: assert property (
        (wr_cnt_flag & pwdata[CMPD_LSB + 2] & ~cmpd_set[2]) |=> ~cmpd_q[2])
        else $error("down compare flag not cleared");
    a_cmpu_clear: assert property (
        (wr_cnt_flag & pwdata[CMPU_LSB + 3] & ~cmpu_set[3]) |=> ~cmpu_q[3])
        else $error("up compare flag not cleared");
    a_odd_follow: assert property (
        (comp_mode[2] & cnt_ev.cmp_hit[5] & cnt_ev.cnt_up[4]
            & ~(cnt_ev.cmp_eq_per[5] & cnt_ev.type_up[4])) |=> cmpu_q[5])
        else $error("odd channel missed even direction");

    // Period and zero points
    a_per_set: assert property (
        cnt_ev.per_hit[0] |=> per_q[0])
        else $error("period flag not set");
    a_per_clear: assert property (
        (wr_cnt_flag & pwdata[PER_LSB] & ~per_set[0]) |=> ~per_q[0])
        else $error("period flag not cleared");
    a_zero_set: assert property (
        cnt_ev.zero_hit[4] |=> zero_q[4])
        else $error("zero flag not set");

    // Enable writes land as written
    a_lien_write: assert property (
        wr_brk_ien |=> lien_q == $past(lien_wdata))
        else $error("level brake enable not written");
    a_eien_write: assert property (
        wr_brk_ien |=> eien_q == $past(eien_wdata))
        else $error("edge brake enable not written");

    // Level brake state and event flag
    a_lstate_set: assert property (
        lvl_fall[0] |=> lstate_q[0] & lstate_q[1])
        else $error("level brake state not set for pair");
    a_lstate_nowr: assert property (
        (wr_brk_flag & ~lstate_q[0] & ~lvl_fall[0]) |=> ~lstate_q[0])
        else $error("level brake state set by software");
    a_lif_set: assert property (
        lvl_fall[0] |=> lif_q[0] & lif_q[1])
        else $error("level event flags not set for pair");
    a_lif_clear: assert property (
        (wr_brk_prot & pwdata[LIF_LSB] & ~lvl_fall[0]) |=> ~lif_q[0])
        else $error("level event flag not cleared");

    // Edge brake state and event flag
    a_estate_free: assert property (
        (wr_brk_flag & ~regs_unlocked & pwdata[ESTATE_LSB + 2] & ~edge_fall[1]) |=> ~estate_q[2])
        else $error("edge state not cleared while locked");
    a_eif_lock: assert property (
        (eif_q[2] & ~regs_unlocked) |=> eif_q[2])
        else $error("edge event flag cleared while locked");
    a_eif_clear: assert property (
        (wr_brk_prot & pwdata[EIF_LSB + 2] & ~edge_fall[1]) |=> ~eif_q[2])
        else $error("edge event flag not cleared");

    // Interrupt follows enabled flags
    a_irq_edge: assert property (
        (eif_q[2] & eien_q[1]) |=> irq)
        else $error("irq missing for edge flag");
    a_irq_cnt: assert property (
        (cmpu_q[5] & cnt_ien_q[CMPU_LSB + 5]) |=> irq)
        else $error("irq missing for counter flag");
    a_irq_quiet: assert property (
        ((cnt_flag_word & cnt_ien_q) == RESET_WORD && (lif_q & lien_ch) == RESET_FLAGS
            && (eif_q & eien_ch) == RESET_FLAGS) |=> !irq)
        else $error("irq raised with no enabled flag");

    // Bus answer timing
    a_ready_wait: assert property (
        (psel & penable & ~pready) |=> pready)
        else $error("pready not raised after one wait");
    a_err_unmapped: assert property (
        (psel & penable & ~pready & ~mapped_w) |=> pslverr)
        else $error("unmapped access without error");
    a_rdata_idle: assert property (
        !pready |-> prdata == RESET_WORD)
        else $error("read data outside answer cycle");

endmodule : pwm_interrupt_flags_and_brake_status

// ==== rtl/pwm_irq_pkg.sv ====
// Register map, field positions and carrier types of the PWM interrupt flag block
package pwm_irq_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_CNT_IEN = 12'h0E0;
    localparam logic [11:0] OFF_BRK_IEN = 12'h0E4;
    localparam logic [11:0] OFF_CNT_FLAG = 12'h0E8;
    localparam logic [11:0] OFF_BRK_FLAG = 12'h0EC;
    localparam int ADDR_W = 12;

    // Channel counts
    localparam int NCH = 6;
    localparam int NPAIR = 3;

    // Counter flag fields
    localparam int CMPD_LSB = 24;
    localparam int CMPU_LSB = 16;
    localparam int PER_LSB = 8;
    localparam int ZERO_LSB = 0;

    // Brake flag and state fields
    localparam int LSTATE_LSB = 24;
    localparam int ESTATE_LSB = 16;
    localparam int LIF_LSB = 8;
    localparam int EIF_LSB = 0;

    // Brake interrupt enable fields
    localparam int LIEN_LSB = 8;
    localparam int EIEN_LSB = 0;

    // Only channels 0, 2 and 4 own period and zero flags
    localparam logic [5:0] EVEN_MASK = 6'h15;

    // Implemented bits of the counter interrupt enable word
    localparam logic [31:0] CNT_IEN_MASK = 32'h3F3F_1515;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [5:0] RESET_FLAGS = 6'h00;
    localparam logic [2:0] RESET_PAIR = 3'h0;

    // Per-channel counter events from the counter logic, same clock
    typedef struct packed {
        logic [5:0] cmp_hit;
        logic [5:0] cnt_up;
        logic [5:0] cnt_down;
        logic [5:0] per_hit;
        logic [5:0] zero_hit;
        logic [5:0] cmp_eq_per;
        logic [5:0] type_up;
        logic [5:0] type_down;
        logic [5:0] per_end;
    } cnt_events_t;

    // Per-pair brake sources, active low, asynchronous
    typedef struct packed {
        logic [2:0] lvl_n;
        logic [2:0] edge_n;
    } brake_in_t;
endpackage : pwm_irq_pkg

// ==== verification/pwm_interrupt_flags_and_brake_status_bench.sv ====
// Self-checking APB bench for the PWM interrupt flag and brake status block
`timescale 1ns/1ps
module pwm_interrupt_flags_and_brake_status_bench
    import pwm_irq_pkg::*;
;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cnt_events_t cnt_ev;
    logic [2:0] comp_mode;
    brake_in_t brake_src;
    logic regs_unlocked;
    logic irq;
    logic [31:0] rd_data;
    logic rd_err;
    int n_errors;
    int n_compared;

    pwm_interrupt_flags_and_brake_status dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cnt_ev(cnt_ev), .comp_mode(comp_mode), .brake_src(brake_src),
        .regs_unlocked(regs_unlocked), .irq(irq)
    );

    always #25 pclk = ~pclk;

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk_word(input logic [31:0] act, input logic [31:0] exp);
        n_compared++;
        if (act !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic act, input logic exp);
        n_compared++;
        if (act !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : chk_bit

    // Bounded wait on pready; data and error taken at the same edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && !done; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                done = 1'b1;
                rd_data = prdata;
                rd_err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!done) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            end_sim();
        end
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_word(rd_data, exp);
    endtask : rd_chk

    // Events are levels held for exactly one cycle
    task automatic pulse(input cnt_events_t v);
        @(posedge pclk);
        cnt_ev <= v;
        @(posedge pclk);
        cnt_ev <= '0;
    endtask : pulse

    task automatic lock(input logic open);
        @(posedge pclk);
        regs_unlocked <= open;
    endtask : lock

    initial begin
        cnt_events_t ev;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        cnt_ev = '0;
        comp_mode = 3'h0;
        brake_src = '1;
        regs_unlocked = 1'b0;
        n_errors = 0;
        n_compared = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(OFF_CNT_FLAG, 32'h0000_0000);
        rd_chk(OFF_BRK_FLAG, 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk_bit(rd_err, 1'b1);
        // Compare flags, with the compare-equals-period exclusions first
        ev = '0;
        ev.cmp_hit[3] = 1'b1;
        ev.cnt_up[3] = 1'b1;
        ev.cmp_eq_per[3] = 1'b1;
        ev.type_up[3] = 1'b1;
        pulse(ev);
        rd_chk(OFF_CNT_FLAG, 32'h0000_0000);
        ev.cmp_eq_per[3] = 1'b0;
        ev.type_up[3] = 1'b0;
        pulse(ev);
        rd_chk(OFF_CNT_FLAG, 32'h0008_0000);
        ev = '0;
        ev.cmp_hit[2] = 1'b1;
        ev.cnt_down[2] = 1'b1;
        ev.cmp_eq_per[2] = 1'b1;
        ev.type_down[2] = 1'b1;
        pulse(ev);
        rd_chk(OFF_CNT_FLAG, 32'h0008_0000);
        ev.cmp_eq_per[2] = 1'b0;
        ev.type_down[2] = 1'b0;
        pulse(ev);
        rd_chk(OFF_CNT_FLAG, 32'h0408_0000);
        ev = '0;
        ev.per_hit = 6'h3F;
        ev.zero_hit = 6'h3F;
        pulse(ev);
        rd_chk(OFF_CNT_FLAG, 32'h0408_1515);
        wr(OFF_CNT_FLAG, 32'h0408_1515);
        rd_chk(OFF_CNT_FLAG, 32'h0000_0000);
        // Odd channel follows the even channel's direction
        comp_mode <= 3'h4;
        ev = '0;
        ev.cnt_up[4] = 1'b1;
        ev.cmp_hit[5] = 1'b1;
        pulse(ev);
        rd_chk(OFF_CNT_FLAG, 32'h0020_0000);
        chk_bit(irq, 1'b0);
        wr(OFF_CNT_IEN, 32'hFFFF_FFFF);
        rd_chk(OFF_CNT_IEN, 32'h3F3F_1515);
        repeat (2) @(posedge pclk);
        chk_bit(irq, 1'b1);
        wr(OFF_CNT_FLAG, 32'h0020_0000);
        repeat (2) @(posedge pclk);
        chk_bit(irq, 1'b0);
        wr(OFF_CNT_IEN, 32'h0000_0000);
        comp_mode <= 3'h0;
        // Brake enables only take writes while unlocked
        wr(OFF_BRK_IEN, 32'hFFFF_FFFF);
        rd_chk(OFF_BRK_IEN, 32'h0000_0000);
        lock(1'b1);
        wr(OFF_BRK_IEN, 32'hFFFF_FFFF);
        rd_chk(OFF_BRK_IEN, 32'h0000_0707);
        wr(OFF_BRK_IEN, 32'h0000_0100);
        lock(1'b0);
        // Level brake on pair 0/1
        @(posedge pclk);
        brake_src.lvl_n[0] <= 1'b0;
        repeat (6) @(posedge pclk);
        rd_chk(OFF_BRK_FLAG, 32'h0300_0300);
        chk_bit(irq, 1'b1);
        wr(OFF_BRK_FLAG, 32'hFFFF_FFFF);
        rd_chk(OFF_BRK_FLAG, 32'h0300_0300);
        brake_src.lvl_n[0] <= 1'b1;
        repeat (6) @(posedge pclk);
        rd_chk(OFF_BRK_FLAG, 32'h0300_0300);
        ev = '0;
        ev.per_end = 6'h3F;
        pulse(ev);
        rd_chk(OFF_BRK_FLAG, 32'h0000_0300);
        lock(1'b1);
        wr(OFF_BRK_FLAG, 32'h0000_0300);
        rd_chk(OFF_BRK_FLAG, 32'h0000_0000);
        chk_bit(irq, 1'b0);
        // Edge brake on pair 2/3
        wr(OFF_BRK_IEN, 32'h0000_0002);
        lock(1'b0);
        @(posedge pclk);
        brake_src.edge_n[1] <= 1'b0;
        repeat (6) @(posedge pclk);
        rd_chk(OFF_BRK_FLAG, 32'h000C_000C);
        chk_bit(irq, 1'b1);
        wr(OFF_BRK_FLAG, 32'h000C_0000);
        rd_chk(OFF_BRK_FLAG, 32'h0000_000C);
        wr(OFF_BRK_FLAG, 32'h0000_000C);
        rd_chk(OFF_BRK_FLAG, 32'h0000_000C);
        lock(1'b1);
        wr(OFF_BRK_FLAG, 32'h0000_000C);
        rd_chk(OFF_BRK_FLAG, 32'h0000_0000);
        chk_bit(irq, 1'b0);
        brake_src.edge_n[1] <= 1'b1;
        // Mid-run reset clears the enables
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(OFF_BRK_IEN, 32'h0000_0000);
        end_sim();
    end
endmodule : pwm_interrupt_flags_and_brake_status_bench
